// *** pds_cfg.svh ***
/*
  Constants of the power-down park sequencer: output reset values, timing
  figures with cycle counts for all but the two hold times, and the bounds of the clock ratio check.
  Assumes the main clock runs at PDS_CLK_MHZ.
*/
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH

`define PDS_CLK_MHZ 250

// Output levels held from reset onward.
`define PDS_PARK_RST 1'b1
`define PDS_CTRL_RST_RST 1'b1
`define PDS_DISCH_RST 1'b0
`define PDS_FAULT_RST 1'b0

// Sequence times in microseconds.
`define PDS_T_MON4_MIN_US 52
`define PDS_T_MON4_MAX_US 120
`define PDS_T_MON5_MAX_US 1000
`define PDS_T_PARK_MAX_US 280
`define PDS_T_W2_MAX_US 500
`define PDS_T_VHOLD1_US 900
`define PDS_T_VHOLD2_US 1780

// Cycle counts; whole microseconds at a whole MHz rate need no rounding.
`define PDS_MON4_MIN_CYC (`PDS_T_MON4_MIN_US * `PDS_CLK_MHZ)
`define PDS_MON4_MAX_CYC (`PDS_T_MON4_MAX_US * `PDS_CLK_MHZ)
`define PDS_MON5_MAX_CYC (`PDS_T_MON5_MAX_US * `PDS_CLK_MHZ)
`define PDS_PARK_MAX_CYC (`PDS_T_PARK_MAX_US * `PDS_CLK_MHZ)
`define PDS_W2_MAX_CYC (`PDS_T_W2_MAX_US * `PDS_CLK_MHZ)

// Clock ratio check, frequencies in kHz, tolerances in percent.
`define PDS_SEQ_NOM_KHZ 30000
`define PDS_OSC_NOM_KHZ 2000
`define PDS_OSC_MIN_KHZ 1760
`define PDS_OSC_MAX_KHZ 2240
`define PDS_SS_DOWN_PCT 2
`define PDS_JIT_PCT 3
`define PDS_WIN_OSC 64
`define PDS_SEQ_CNT_LO \
  (`PDS_SEQ_NOM_KHZ * (100 - `PDS_SS_DOWN_PCT - `PDS_JIT_PCT) * `PDS_WIN_OSC \
   / (`PDS_OSC_MAX_KHZ * 100))
`define PDS_SEQ_CNT_HI \
  (`PDS_SEQ_NOM_KHZ * (100 + `PDS_JIT_PCT) * `PDS_WIN_OSC / (`PDS_OSC_MIN_KHZ * 100) + 1)

`endif

// *** pds_pkg.sv ***
/*
  Types of the power-down park sequencer.
  Assumes nothing of its surroundings.
*/
package pds_pkg;

  typedef enum logic [2:0] {
    PDS_RUN = 3'h0,
    PDS_WAIT_PARK = 3'h1,
    PDS_PARKED = 3'h2,
    PDS_DISCHARGE = 3'h3,
    PDS_DONE = 3'h4
  } pds_state_type;

  typedef enum logic {
    PDS_SRC_REQUEST = 1'b0,
    PDS_SRC_SUPPLY = 1'b1
  } pds_src_type;

endpackage

// *** pds_clk_check.sv ***
/*
  Sequencer clock ratio check: counts sequencer clock edges over a window of
  internal oscillator cycles and flags a count outside the tolerated band.
  Assumes both clock pins are sampled as data by the 250 MHz main clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pds_cfg.svh"

module pds_clk_check #(
  parameter int unsigned P_WIN = `PDS_WIN_OSC,
  parameter int unsigned P_CNT_W = 12
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_sequencer_clock_in,
  input wire logic i_osc_in,
  output logic o_clock_fault
);
  import pds_pkg::*;

  localparam logic [P_CNT_W-1:0] C_LO = P_CNT_W'(`PDS_SEQ_CNT_LO);
  localparam logic [P_CNT_W-1:0] C_HI = P_CNT_W'(`PDS_SEQ_CNT_HI);
  localparam int unsigned C_WIN_W = $clog2(P_WIN);

  logic seq_d_r, seq_d_nxt, osc_d_r, osc_d_nxt;
  logic [C_WIN_W-1:0] win_r, win_nxt;
  logic [P_CNT_W-1:0] cnt_r, cnt_nxt;
  logic fault_r, fault_nxt;
  logic seq_rise, osc_rise, win_end;
  logic [P_CNT_W-1:0] cnt_inc;

  assign seq_rise = i_sequencer_clock_in & ~seq_d_r;
  // The count including this cycle's edge, kept apart so the window check sees it.
  assign cnt_inc = (seq_rise && cnt_r != '1) ? cnt_r + 1'b1 : cnt_r;
  assign osc_rise = i_osc_in & ~osc_d_r;
  assign win_end = osc_rise && (win_r == C_WIN_W'(P_WIN - 1));

  always_comb
  begin
    seq_d_nxt = i_sequencer_clock_in;
    osc_d_nxt = i_osc_in;
    win_nxt = osc_rise ? win_r + 1'b1 : win_r;
    cnt_nxt = cnt_inc;
    fault_nxt = fault_r;
    if (win_end)
    begin
      // A band wide enough for oscillator spread, down-spread and jitter.
      fault_nxt = (cnt_inc < C_LO) || (cnt_inc > C_HI);
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      seq_d_r <= 1'b0;
      osc_d_r <= 1'b0;
      win_r <= '0;
      cnt_r <= '0;
      fault_r <= `PDS_FAULT_RST;
    end
    else
    begin
      seq_d_r <= seq_d_nxt;
      osc_d_r <= osc_d_nxt;
      win_r <= win_nxt;
      cnt_r <= cnt_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign o_clock_fault = fault_r;

  a_ratio_fault: assert property (@(posedge i_clock) disable iff (!i_nrst)
    win_end |=> (fault_r == (($past(cnt_inc) < C_LO) || ($past(cnt_inc) > C_HI))))
    else $error("clock ratio fault does not match the window count");

  a_fault_steady: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !win_end |=> $stable(fault_r))
    else $error("clock fault changed outside a window end");

endmodule // pds_clk_check
`default_nettype wire

// *** pds_sequencer.sv ***
/*
  Power-down park sequencer: on a main supply trip or a dropped power request
  it parks the mirrors, disables and discharges the mirror rails, then holds
  the controller in reset, and it checks the sequencer clock ratio.
  Assumes all inputs are synchronous to i_clock and that the host keeps the
  input supplies valid for the hold times after a trigger.
*/
// Overview of operation
// - A main supply trip starts power-down without any host action.
// - Host pulling the power request low starts the same power-down.
// - After a supply trip seen in PDS_RUN, park falls between 52 and 120 us.
// - After the power request falls, park falls within 1 ms.
// - Within 280 us of park falling, rails are disabled and discharge starts.
// - Within 500 us of discharge start, controller reset falls.
// - Sequencer clock ratio is checked against the internal oscillator.
// - Check tolerates -2% down-spread and 3% jitter without a fault.
`timescale 1ns/100ps
`default_nettype none
`include "pds_cfg.svh"

module pds_sequencer #(
  parameter int unsigned P_TRIP_CYC = `PDS_MON4_MIN_CYC,
  parameter int unsigned P_REQ_CYC = `PDS_MON5_MAX_CYC,
  parameter int unsigned P_PARK_CYC = `PDS_PARK_MAX_CYC,
  parameter int unsigned P_DISCH_CYC = `PDS_W2_MAX_CYC,
  parameter int unsigned P_CNT_W = 18
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_main_supply_sense,
  input wire logic i_power_request_in,
  input wire logic i_power_up_start,
  input wire logic i_sequencer_clock_in,
  input wire logic i_osc_in,
  output logic o_mirror_park_out_n,
  output logic o_rail_discharge,
  output logic o_controller_reset_out_n,
  output pds_pkg::pds_src_type o_trigger_source,
  output logic o_clock_fault
);
  import pds_pkg::*;

  pds_state_type state_r, state_nxt;
  pds_src_type src_r, src_nxt;
  logic [P_CNT_W-1:0] cnt_r, cnt_nxt;
  logic park_n_r, park_n_nxt;
  logic disch_r, disch_nxt;
  logic ctrl_rst_n_r, ctrl_rst_n_nxt;
  logic supply_trip, request_drop;

  // The sense input is high while the main supply is above its trip level.
  assign supply_trip = ~i_main_supply_sense;
  assign request_drop = ~i_power_request_in;

  always_comb
  begin
    state_nxt = state_r;
    src_nxt = src_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    park_n_nxt = park_n_r;
    disch_nxt = disch_r;
    ctrl_rst_n_nxt = ctrl_rst_n_r;
    unique case (state_r)
      PDS_RUN:
      begin
        // A supply trip outranks a request seen in the same cycle, because
        // it leaves the host less time on its supplies.
        if (supply_trip)
        begin
          state_nxt = PDS_WAIT_PARK;
          src_nxt = PDS_SRC_SUPPLY;
          cnt_nxt = P_CNT_W'(P_TRIP_CYC - 1);
        end
        else if (request_drop)
        begin
          state_nxt = PDS_WAIT_PARK;
          src_nxt = PDS_SRC_REQUEST;
          cnt_nxt = P_CNT_W'(P_REQ_CYC - 1);
        end
      end
      PDS_WAIT_PARK:
      begin
        // Triggers are no longer looked at here, so the delay never restarts.
        if (cnt_r == '0)
        begin
          state_nxt = PDS_PARKED;
          park_n_nxt = 1'b0;
          cnt_nxt = P_CNT_W'(P_PARK_CYC - 1);
        end
      end
      PDS_PARKED:
      begin
        if (cnt_r == '0)
        begin
          state_nxt = PDS_DISCHARGE;
          disch_nxt = 1'b1;
          cnt_nxt = P_CNT_W'(P_DISCH_CYC - 1);
        end
      end
      PDS_DISCHARGE:
      begin
        if (cnt_r == '0)
        begin
          state_nxt = PDS_DONE;
          ctrl_rst_n_nxt = 1'b0;
        end
      end
      PDS_DONE:
      begin
        // Outputs stay parked and in reset until a fresh power-up.
        if (i_power_up_start && !supply_trip && !request_drop)
        begin
          state_nxt = PDS_RUN;
          park_n_nxt = `PDS_PARK_RST;
          disch_nxt = `PDS_DISCH_RST;
          ctrl_rst_n_nxt = `PDS_CTRL_RST_RST;
        end
      end
      default:
      begin
        state_nxt = PDS_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_r <= PDS_RUN;
      src_r <= PDS_SRC_REQUEST;
      cnt_r <= '0;
      park_n_r <= `PDS_PARK_RST;
      disch_r <= `PDS_DISCH_RST;
      ctrl_rst_n_r <= `PDS_CTRL_RST_RST;
    end
    else
    begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      cnt_r <= cnt_nxt;
      park_n_r <= park_n_nxt;
      disch_r <= disch_nxt;
      ctrl_rst_n_r <= ctrl_rst_n_nxt;
    end
  end

  assign o_mirror_park_out_n = park_n_r;
  assign o_rail_discharge = disch_r;
  assign o_controller_reset_out_n = ctrl_rst_n_r;
  assign o_trigger_source = src_r;

  pds_clk_check u_clk_check (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_sequencer_clock_in(i_sequencer_clock_in),
    .i_osc_in(i_osc_in),
    .o_clock_fault(o_clock_fault)
  );

  // Helper for the checks below: cycles spent in the current state.
  logic [P_CNT_W-1:0] ph_r;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      ph_r <= '0;
    else if (state_nxt != state_r)
      ph_r <= '0;
    else if (ph_r != '1)
      ph_r <= ph_r + 1'b1;
  end

  sequence s_run_trip;
    (state_r == PDS_RUN) && supply_trip;
  endsequence

  sequence s_run_request;
    (state_r == PDS_RUN) && !supply_trip && request_drop;
  endsequence

  a_trip_starts: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_run_trip |=> (state_r == PDS_WAIT_PARK) && (src_r == PDS_SRC_SUPPLY) && park_n_r)
    else $error("supply trip did not start power-down");

  a_request_starts: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_run_request |=> (state_r == PDS_WAIT_PARK) && (src_r == PDS_SRC_REQUEST))
    else $error("power request drop did not start power-down");

  a_trip_park_time: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ($fell(park_n_r) && src_r == PDS_SRC_SUPPLY) |->
      ($past(ph_r) + 1 >= `PDS_MON4_MIN_CYC) && ($past(ph_r) + 1 <= `PDS_MON4_MAX_CYC))
    else $error("park after supply trip outside its window");

  a_req_park_time: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ($fell(park_n_r) && src_r == PDS_SRC_REQUEST) |->
      ($past(ph_r) + 1 <= `PDS_MON5_MAX_CYC))
    else $error("park after request drop too late");

  a_park_to_disch: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(disch_r) |-> !park_n_r && ($past(ph_r) + 1 <= `PDS_PARK_MAX_CYC))
    else $error("rail discharge too late after park");

  a_disch_to_reset: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $fell(ctrl_rst_n_r) |-> disch_r && ($past(ph_r) + 1 <= `PDS_W2_MAX_CYC))
    else $error("controller reset too late after discharge");

  a_order_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state_r == PDS_DONE && !i_power_up_start) |=>
      (state_r == PDS_DONE) && !park_n_r && disch_r && !ctrl_rst_n_r)
    else $error("power-down outputs released without power-up");

  a_first_wins: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state_r != PDS_RUN && state_r != PDS_DONE) |=> $stable(src_r) && (state_r != PDS_RUN))
    else $error("power-down restarted or trigger source changed midway");

endmodule // pds_sequencer
`default_nettype wire

// *** pds_host_model.sv ***
/*
  Host and supply model: triggers, the two clock pins and supply valid.
  Assumes bench commands change at falling edges of i_clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pds_cfg.svh"
module pds_host_model #(
  parameter int unsigned P_HOLD_TRIP = `PDS_T_VHOLD1_US * `PDS_CLK_MHZ,
  parameter int unsigned P_HOLD_REQ = `PDS_T_VHOLD2_US * `PDS_CLK_MHZ
) (
  input wire logic i_clock,
  input wire logic i_trip,
  input wire logic i_drop,
  input wire logic i_start,
  input wire logic [7:0] i_seq_step,
  output logic o_main_supply_sense,
  output logic o_power_request_in,
  output logic o_power_up_start,
  output logic o_sequencer_clock_in,
  output logic o_osc_in,
  output logic o_supply_valid
);
  // Phase accumulators keep both clock pins on falling edges, so no race.
  localparam int unsigned OSC_STEP = 2 * `PDS_OSC_NOM_KHZ / 1000;
  int unsigned held = 0;
  int unsigned seq_acc = 0;
  int unsigned osc_acc = 0;
  logic seq_r = 1'b0;
  logic osc_r = 1'b0;
  assign o_main_supply_sense = !i_trip;
  assign o_power_request_in = !i_drop;
  assign o_power_up_start = i_start;
  assign o_sequencer_clock_in = seq_r;
  assign o_osc_in = osc_r;
  assign o_supply_valid = held < (i_trip ? P_HOLD_TRIP : P_HOLD_REQ);
  always @(negedge i_clock)
  begin
    held <= (i_trip || i_drop) ? held + 1 : 0;
    seq_acc = seq_acc + i_seq_step;
    osc_acc = osc_acc + OSC_STEP;
    if (seq_acc >= `PDS_CLK_MHZ)
    begin
      seq_acc = seq_acc - `PDS_CLK_MHZ;
      seq_r <= !seq_r;
    end
    if (osc_acc >= `PDS_CLK_MHZ)
    begin
      osc_acc = osc_acc - `PDS_CLK_MHZ;
      osc_r <= !osc_r;
    end
  end
endmodule // pds_host_model
`default_nettype wire

// *** tb_power_down_park_sequencer.sv ***
/*
  Self-checking bench of the power-down park sequencer and its host model.
  Assumes shortened request, park and discharge counts set below.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pds_cfg.svh"
module tb_power_down_park_sequencer;
  import pds_pkg::*;
  localparam int unsigned REQ_CYC = 30;
  localparam int unsigned PARK_CYC = 10;
  localparam int unsigned DISCH_CYC = 12;
  localparam int unsigned WIN_CYC = 2 * `PDS_WIN_OSC * `PDS_CLK_MHZ * 1000 / `PDS_OSC_NOM_KHZ + 100;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic trip = 1'b0;
  logic drop = 1'b0;
  logic start = 1'b0;
  logic [7:0] seq_step = 8'h3c;
  wire logic sense, request, pup, sequencer_clock_in, osc, supply_valid;
  wire logic park_n, disch, ctrl_rst_n, fault;
  pds_src_type src;
  int failures = 0;
  int checks = 0;

  initial
  begin
    forever #2 clock = !clock;
  end

  pds_host_model i_host (
    .i_clock(clock), .i_trip(trip), .i_drop(drop), .i_start(start), .i_seq_step(seq_step),
    .o_main_supply_sense(sense), .o_power_request_in(request), .o_power_up_start(pup),
    .o_sequencer_clock_in(sequencer_clock_in), .o_osc_in(osc), .o_supply_valid(supply_valid)
  );

  pds_sequencer #(.P_REQ_CYC(REQ_CYC), .P_PARK_CYC(PARK_CYC), .P_DISCH_CYC(DISCH_CYC)) i_dut (
    .i_clock(clock), .i_nrst(nrst), .i_main_supply_sense(sense),
    .i_power_request_in(request), .i_power_up_start(pup),
    .i_sequencer_clock_in(sequencer_clock_in), .i_osc_in(osc),
    .o_mirror_park_out_n(park_n), .o_rail_discharge(disch),
    .o_controller_reset_out_n(ctrl_rst_n), .o_trigger_source(src), .o_clock_fault(fault)
  );

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int unsigned got, input int unsigned lo, input int unsigned hi);
    checks++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Counts falling edges until park falls (0), discharge rises (1) or reset falls (2).
  task automatic wait_for(input int sel, input int unsigned limit, output int unsigned n);
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end while (n < limit && !(sel == 0 ? park_n === 1'b0 :
                              sel == 1 ? disch === 1'b1 : ctrl_rst_n === 1'b0));
  endtask

  // The trigger source is not cleared on power-up, so it keeps the last sequence's value.
  task automatic check_idle(input pds_src_type exp);
    check_bit(park_n, 1'b1);
    check_bit(disch, 1'b0);
    check_bit(ctrl_rst_n, 1'b1);
    check_bit(src, exp);
  endtask

  task automatic run_seq(input int unsigned lo, input int unsigned hi, input int unsigned pre,
                         input pds_src_type exp);
    int unsigned n;
    wait_for(0, hi + 10, n);
    check_range(n + pre, lo, hi);
    check_bit(disch, 1'b0);
    check_bit(src, exp);
    wait_for(1, PARK_CYC + 10, n);
    check_range(n, 1, PARK_CYC);
    check_bit(ctrl_rst_n, 1'b1);
    wait_for(2, DISCH_CYC + 10, n);
    check_range(n, 1, DISCH_CYC);
    check_bit(supply_valid, 1'b1);
    repeat (40) @(negedge clock);
    check_bit(park_n, 1'b0);
    check_bit(disch, 1'b1);
    check_bit(ctrl_rst_n, 1'b0);
  endtask

  // Power-up start is refused while a trigger level is still present.
  task automatic restore(input pds_src_type exp);
    start = 1'b1;
    repeat (2) @(negedge clock);
    check_bit(park_n, 1'b0);
    trip = 1'b0;
    drop = 1'b0;
    repeat (2) @(negedge clock);
    start = 1'b0;
    @(negedge clock);
    check_idle(exp);
  endtask

  task automatic test_request();
    drop = 1'b1;
    repeat (3) @(negedge clock);
    trip = 1'b1;
    run_seq(REQ_CYC, REQ_CYC + 1, 3, PDS_SRC_REQUEST);
    restore(PDS_SRC_REQUEST);
    $display("test_request done");
  endtask

  task automatic test_trip();
    trip = 1'b1;
    repeat (3) @(negedge clock);
    drop = 1'b1;
    run_seq(`PDS_MON4_MIN_CYC, `PDS_MON4_MAX_CYC + 1, 3, PDS_SRC_SUPPLY);
    check_bit(fault, 1'b0);
    restore(PDS_SRC_SUPPLY);
    $display("test_trip done");
  endtask

  // Both triggers in one cycle: the supply trip must win.
  task automatic test_both();
    trip = 1'b1;
    drop = 1'b1;
    run_seq(`PDS_MON4_MIN_CYC, `PDS_MON4_MAX_CYC + 1, 0, PDS_SRC_SUPPLY);
    restore(PDS_SRC_SUPPLY);
    $display("test_both done");
  endtask

  task automatic test_reset_mid();
    drop = 1'b1;
    repeat (REQ_CYC + PARK_CYC) @(negedge clock);
    nrst = 1'b0;
    drop = 1'b0;
    #1;
    check_idle(PDS_SRC_REQUEST);
    @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    check_idle(PDS_SRC_REQUEST);
    check_bit(fault, 1'b0);
    $display("test_reset_mid done");
  endtask

  task automatic test_clock();
    logic [7:0] steps [3] = '{8'h3b, 8'h28, 8'h48};
    logic exp [3] = '{1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 3; i++)
    begin
      seq_step = steps[i];
      repeat (WIN_CYC) @(negedge clock);
      check_bit(fault, exp[i]);
    end
    seq_step = 8'h3c;
    $display("test_clock done");
  endtask

  initial
  begin
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    check_idle(PDS_SRC_REQUEST);
    test_request();
    test_trip();
    test_reset_mid();
    test_both();
    test_clock();
    give_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge clock);
    failures++;
    give_verdict();
  end
endmodule // tb_power_down_park_sequencer
`default_nettype wire
